// ---- pkg/wrs_pkg.sv ----
package wrs_pkg;
    localparam int DATA_W        = 16;
    localparam int BYTE_W        = 8;
    localparam int ADDR_W        = 24;
    localparam logic [7:0] STACK_BANK = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] ONE_STEP   = 16'h0001;
    localparam logic [15:0] INT_FRAME  = 16'h0005;

    // register selector for loads
    typedef enum logic [2:0] {
        WRS_SEL_ACC_A,
        WRS_SEL_ACC_B,
        WRS_SEL_IDX_X,
        WRS_SEL_IDX_Y,
        WRS_SEL_STACK
    } wrs_sel_t;

    // stack sequence requests
    typedef enum logic [1:0] {
        WRS_OP_NONE,
        WRS_OP_INTERRUPT,
        WRS_OP_CALL,
        WRS_OP_RETURN
    } wrs_op_t;

    // one register write request
    typedef struct packed {
        logic        en;
        wrs_sel_t    sel;
        logic [15:0] data;
    } wrs_wr_t;

    // return state moved through the stack
    typedef struct packed {
        logic [7:0]  program_bank;
        logic [15:0] program_counter;
        logic [15:0] status_word;
    } wrs_frame_t;

    // one stack memory access
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [23:0] addr;
        logic [7:0]  wdata;
    } wrs_mem_t;
endpackage

// ---- design/wrs_regset.sv ----
`timescale 1ns/1ns
// Overview of operation
// - accumulator a is 16 bits, low byte usable alone
// - data width flag set writes only accumulator low byte, high kept
// - accumulator b mirrors a, following the same data width flag
// - index x is 16 bits; 8-bit mode writes low byte only
// - indexed address is index x plus instruction operand
// - block move source is operand third byte and index x
// - block move destination is operand second byte and index y
// - index y behaves like x under the same index width flag
// - stack pointer is 16 bits; stack accesses go to bank zero
// - interrupt pushes program bank first, then counter, then status word
// - after interrupt entry the stack pointer is five less
// - interrupt return pops status, counter, bank; pointer restored
// - calls push no status word; bank push chosen by caller
// - stack pointer undefined at reset; software loads it first
// - data width flag clear means 16-bit, cleared at reset
// - index width flag clear means 16-bit index, cleared at reset
module wrs_regset (
    // clock and control
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    // width flags
    input  wire logic                data_w8_set,
    input  wire logic                data_w8_clr,
    input  wire logic                idx_w8_set,
    input  wire logic                idx_w8_clr,
    // register write port
    input  wire wrs_pkg::wrs_wr_t    wr,
    // address operands
    input  wire logic [23:0]         index_operand,
    input  wire logic [7:0]          move_src_bank,
    input  wire logic [7:0]          move_dst_bank,
    // stack sequence request
    input  wire wrs_pkg::wrs_op_t    stack_op,
    input  wire logic                call_push_bank,
    input  wire wrs_pkg::wrs_frame_t push_frame,
    input  wire logic [7:0]          mem_rdata,
    input  wire logic                mem_ready,
    // register contents
    output logic [15:0]              acc_a,
    output logic [15:0]              acc_b,
    output logic [15:0]              idx_x,
    output logic [15:0]              idx_y,
    output logic [15:0]              stack_ptr,
    output logic                     data_w8,
    output logic                     idx_w8,
    // formed addresses
    output logic [23:0]              indexed_addr,
    output logic [23:0]              move_src_addr,
    output logic [23:0]              move_dst_addr,
    // stack access and results
    output wrs_pkg::wrs_mem_t        mem,
    output logic                     stack_busy,
    output logic                     stack_done,
    output wrs_pkg::wrs_frame_t      pop_frame
);
    // stack engine: one state per byte moved; pops walk the push order backwards
    typedef enum logic [3:0] {
        WRS_IDLE,
        WRS_PUSH_BANK,
        WRS_PUSH_PC_HI,
        WRS_PUSH_PC_LO,
        WRS_PUSH_ST_HI,
        WRS_PUSH_ST_LO,
        WRS_POP_ST_LO,
        WRS_POP_ST_HI,
        WRS_POP_PC_LO,
        WRS_POP_PC_HI,
        WRS_POP_BANK
    } wrs_state_t;

    // architectural registers and width flags
    logic [15:0]         acc_a_r;
    logic [15:0]         acc_b_r;
    logic [15:0]         idx_x_r;
    logic [15:0]         idx_y_r;
    logic [15:0]         stack_ptr_r;
    logic                data_w8_r;
    logic                idx_w8_r;
    // stack engine
    wrs_state_t          state_r, state_nxt;
    logic                call_r;
    wrs_pkg::wrs_frame_t frame_r;
    logic                done_r;
    logic                step;
    logic                pop_state;
    logic                start;
    // decoded write strobes and index values seen by address formation
    logic                wr_acc_a;
    logic                wr_acc_b;
    logic                wr_idx_x;
    logic                wr_idx_y;
    logic                wr_stack;
    logic [15:0]         idx_x_eff;
    logic [15:0]         idx_y_eff;

    // merge a write under a width flag: narrow mode keeps the upper byte
    function automatic logic [15:0] wrs_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic        narrow);
        wrs_merge = narrow ? {old_v[15:8], new_v[7:0]} : new_v;
    endfunction

    // one register's write strobe: running, requested and addressed to it
    function automatic logic wrs_hit(input wrs_pkg::wrs_wr_t  req,
                                     input logic              run,
                                     input wrs_pkg::wrs_sel_t target);
        wrs_hit = run && req.en && (req.sel == target);
    endfunction

    // index value used for addresses: a narrow index hides its kept upper byte
    function automatic logic [15:0] wrs_index(input logic [15:0] v,
                                              input logic        narrow);
        wrs_index = narrow ? {8'h00, v[7:0]} : v;
    endfunction

    // write strobes, decoded once so every register process sees the same
    // gating; a frozen clock enable blocks all of them together
    assign wr_acc_a = wrs_hit(wr, clk_en, wrs_pkg::WRS_SEL_ACC_A);
    assign wr_acc_b = wrs_hit(wr, clk_en, wrs_pkg::WRS_SEL_ACC_B);
    assign wr_idx_x = wrs_hit(wr, clk_en, wrs_pkg::WRS_SEL_IDX_X);
    assign wr_idx_y = wrs_hit(wr, clk_en, wrs_pkg::WRS_SEL_IDX_Y);
    assign wr_stack = wrs_hit(wr, clk_en, wrs_pkg::WRS_SEL_STACK);

    // width flags; a set request beats a clear in the same cycle
    // both flags clear at reset, so the block starts in full 16-bit mode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_w8_r <= 1'b0;
            idx_w8_r  <= 1'b0;
        end else if (clk_en) begin
            if (data_w8_set)
                data_w8_r <= 1'b1;
            else if (data_w8_clr)
                data_w8_r <= 1'b0;
            if (idx_w8_set)
                idx_w8_r <= 1'b1;
            else if (idx_w8_clr)
                idx_w8_r <= 1'b0;
        end
    end

    // accumulators follow the data width flag
    // a narrow write keeps the upper byte, so a later wide read still sees it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_a_r <= wrs_pkg::RESET_WORD;
            acc_b_r <= wrs_pkg::RESET_WORD;
        end else begin
            if (wr_acc_a)
                acc_a_r <= wrs_merge(acc_a_r, wr.data, data_w8_r);
            if (wr_acc_b)
                acc_b_r <= wrs_merge(acc_b_r, wr.data, data_w8_r);
        end
    end

    // index registers follow the index width flag
    // the kept upper byte reappears as soon as the index goes wide again
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            idx_x_r <= wrs_pkg::RESET_WORD;
            idx_y_r <= wrs_pkg::RESET_WORD;
        end else begin
            if (wr_idx_x)
                idx_x_r <= wrs_merge(idx_x_r, wr.data, idx_w8_r);
            if (wr_idx_y)
                idx_y_r <= wrs_merge(idx_y_r, wr.data, idx_w8_r);
        end
    end

    // narrow index mode feeds only the low byte into every formed address
    assign idx_x_eff = wrs_index(idx_x_r, idx_w8_r);
    assign idx_y_eff = wrs_index(idx_y_r, idx_w8_r);

    // address formation is combinational from register state
    always_comb begin
        indexed_addr  = index_operand + {8'h00, idx_x_eff};
        move_src_addr = {move_src_bank, idx_x_eff};
        move_dst_addr = {move_dst_bank, idx_y_eff};
    end

    // a stack byte completes when the memory side accepts it
    assign step      = clk_en && mem_ready && (state_r != WRS_IDLE);
    assign pop_state = (state_r == WRS_POP_ST_LO) || (state_r == WRS_POP_ST_HI) ||
                       (state_r == WRS_POP_PC_LO) || (state_r == WRS_POP_PC_HI) ||
                       (state_r == WRS_POP_BANK);

    // stack sequencer next state
    // a stalled byte (ready low) holds its state, so every request field stands
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            WRS_IDLE: begin
                unique case (stack_op)
                    wrs_pkg::WRS_OP_INTERRUPT: state_nxt = WRS_PUSH_BANK;
                    wrs_pkg::WRS_OP_CALL:
                        state_nxt = call_push_bank ? WRS_PUSH_BANK : WRS_PUSH_PC_HI;
                    wrs_pkg::WRS_OP_RETURN:    state_nxt = WRS_POP_ST_LO;
                    wrs_pkg::WRS_OP_NONE:      state_nxt = WRS_IDLE;
                endcase
            end
            WRS_PUSH_BANK:  if (step) state_nxt = WRS_PUSH_PC_HI;
            WRS_PUSH_PC_HI: if (step) state_nxt = WRS_PUSH_PC_LO;
            WRS_PUSH_PC_LO: if (step) state_nxt = call_r ? WRS_IDLE : WRS_PUSH_ST_HI;
            WRS_PUSH_ST_HI: if (step) state_nxt = WRS_PUSH_ST_LO;
            WRS_PUSH_ST_LO: if (step) state_nxt = WRS_IDLE;
            WRS_POP_ST_LO:  if (step) state_nxt = WRS_POP_ST_HI;
            WRS_POP_ST_HI:  if (step) state_nxt = WRS_POP_PC_LO;
            WRS_POP_PC_LO:  if (step) state_nxt = WRS_POP_PC_HI;
            WRS_POP_PC_HI:  if (step) state_nxt = WRS_POP_BANK;
            WRS_POP_BANK:   if (step) state_nxt = WRS_IDLE;
            default:        state_nxt = WRS_IDLE;
        endcase
    end

    // sequencer state and the one-cycle completion pulse after the last byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= WRS_IDLE;
            done_r  <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            done_r  <= step && (state_nxt == WRS_IDLE);
        end
    end

    // a request is taken only while idle, so one arriving mid-sequence is dropped
    assign start = (state_r == WRS_IDLE) && (stack_op != wrs_pkg::WRS_OP_NONE);

    // call marker: a call stops after the counter and never stacks the status word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            call_r <= 1'b0;
        end else if (clk_en && start) begin
            call_r <= (stack_op == wrs_pkg::WRS_OP_CALL);
        end
    end

    // frame: captured when a push starts, rebuilt a byte at a time by a pop;
    // a return keeps the old frame until its bytes arrive, so pop_frame is
    // only meaningful once the done pulse has been seen
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame_r <= '0;
        end else if (clk_en) begin
            if (start && stack_op != wrs_pkg::WRS_OP_RETURN)
                frame_r <= push_frame;
            else if (step && pop_state) begin
                // pops rebuild the frame low byte first, reverse of pushing
                unique case (state_r)
                    WRS_POP_ST_LO: frame_r.status_word[7:0]      <= mem_rdata;
                    WRS_POP_ST_HI: frame_r.status_word[15:8]     <= mem_rdata;
                    WRS_POP_PC_LO: frame_r.program_counter[7:0]  <= mem_rdata;
                    WRS_POP_PC_HI: frame_r.program_counter[15:8] <= mem_rdata;
                    WRS_POP_BANK:  frame_r.program_bank          <= mem_rdata;
                    default:       frame_r <= frame_r;
                endcase
            end
        end
    end

    // stack pointer: no reset value, software loads it before use; a load that
    // lands on a cycle where a stack byte steps is dropped, the step has priority
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (step && !pop_state)
                stack_ptr_r <= stack_ptr_r - wrs_pkg::ONE_STEP;
            else if (step && pop_state)
                stack_ptr_r <= stack_ptr_r + wrs_pkg::ONE_STEP;
            else if (wr_stack)
                stack_ptr_r <= wr.data;
        end
    end

    // stack memory request: pushes write at s, pops read at s+1, bank zero;
    // the request is a level held from the state registers, so it stands
    // unchanged until the memory side raises ready
    always_comb begin
        mem.valid = (state_r != WRS_IDLE);
        mem.write = (state_r != WRS_IDLE) && !pop_state;
        mem.addr  = pop_state ? {wrs_pkg::STACK_BANK, stack_ptr_r + wrs_pkg::ONE_STEP}
                              : {wrs_pkg::STACK_BANK, stack_ptr_r};
        unique case (state_r)
            WRS_PUSH_BANK:  mem.wdata = frame_r.program_bank;
            WRS_PUSH_PC_HI: mem.wdata = frame_r.program_counter[15:8];
            WRS_PUSH_PC_LO: mem.wdata = frame_r.program_counter[7:0];
            WRS_PUSH_ST_HI: mem.wdata = frame_r.status_word[15:8];
            WRS_PUSH_ST_LO: mem.wdata = frame_r.status_word[7:0];
            default:        mem.wdata = 8'h00;
        endcase
    end

    // outputs: contents come straight from flip-flops; the mem request and the
    // busy level are decoded from the state register
    assign acc_a      = acc_a_r;
    assign acc_b      = acc_b_r;
    assign idx_x      = idx_x_r;
    assign idx_y      = idx_y_r;
    assign stack_ptr  = stack_ptr_r;
    assign data_w8    = data_w8_r;
    assign idx_w8     = idx_w8_r;
    assign stack_busy = (state_r != WRS_IDLE);
    assign stack_done = done_r;
    assign pop_frame  = frame_r;
endmodule // wrs_regset

// ---- verif/wrs_regset_checker.sv ----
`timescale 1ns/1ns
// port-level watch on the register set
module wrs_regset_checker (
    // clock and control
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic                clk_en,
    input wire logic                mem_ready,
    input wire logic                stack_busy,
    // inputs seen
    input wire wrs_pkg::wrs_wr_t    wr,
    input wire wrs_pkg::wrs_op_t    stack_op,
    input wire wrs_pkg::wrs_frame_t push_frame,
    input wire logic [23:0]         index_operand,
    input wire logic [7:0]          move_src_bank,
    input wire logic [7:0]          move_dst_bank,
    // outputs watched
    input wire logic [15:0]         acc_a,
    input wire logic [15:0]         idx_x,
    input wire logic [15:0]         idx_y,
    input wire logic [15:0]         stack_ptr,
    input wire logic                data_w8,
    input wire logic                idx_w8,
    input wire logic [23:0]         indexed_addr,
    input wire logic [23:0]         move_src_addr,
    input wire logic [23:0]         move_dst_addr,
    input wire wrs_pkg::wrs_mem_t   mem
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // an interrupt request taken while the stack engine is idle
    sequence int_start;
        stack_op == wrs_pkg::WRS_OP_INTERRUPT && !stack_busy && clk_en;
    endsequence

    // the first byte of an interrupt frame is the bank, written at the old pointer
    chk_bank_first: assert property (int_start |=> mem.valid && mem.write
        && mem.addr == {8'h00, $past(stack_ptr)}
        && mem.wdata == $past(push_frame.program_bank)) else $error("bank not pushed first");
    chk_stack_bank: assert property (mem.valid |-> mem.addr[23:16] == 8'h00)
        else $error("stack access outside bank zero");
    chk_push_step: assert property (mem.valid && mem.write && mem_ready && clk_en
        |=> stack_ptr == $past(stack_ptr) - 16'h0001) else $error("pointer not stepped");
    // a pop byte accepted while running
    sequence pop_byte;
        mem.valid && !mem.write && mem_ready && clk_en;
    endsequence

    chk_pop_step: assert property (pop_byte |=> stack_ptr == $past(stack_ptr) + 16'h0001)
        else $error("pointer not restored");
    // a narrow index contributes only its low byte to formed addresses
    chk_index_sum: assert property (indexed_addr == index_operand
        + {8'h00, (idx_w8 ? {8'h00, idx_x[7:0]} : idx_x)})
        else $error("indexed address wrong");
    chk_move_src: assert property (move_src_addr
        == {move_src_bank, (idx_w8 ? {8'h00, idx_x[7:0]} : idx_x)})
        else $error("move source wrong");
    chk_move_dst: assert property (move_dst_addr
        == {move_dst_bank, (idx_w8 ? {8'h00, idx_y[7:0]} : idx_y)})
        else $error("move destination wrong");
    // narrow writes must keep the high byte of the target
    chk_acc_narrow: assert property (wr.en && clk_en && data_w8
        && wr.sel == wrs_pkg::WRS_SEL_ACC_A |=> acc_a == {$past(acc_a[15:8]),
        $past(wr.data[7:0])}) else $error("narrow accumulator write wrong");
    chk_idx_narrow: assert property (wr.en && clk_en && idx_w8
        && wr.sel == wrs_pkg::WRS_SEL_IDX_Y |=> idx_y == {$past(idx_y[15:8]),
        $past(wr.data[7:0])}) else $error("narrow index write wrong");
    chk_flags_reset: assert property ($fell(rst) |-> !data_w8 && !idx_w8)
        else $error("width flags not cleared");
endmodule // wrs_regset_checker

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic ref_clk, rst, clk_en, data_w8_set, data_w8_clr, idx_w8_set, idx_w8_clr;
    logic call_push_bank, mem_ready, stack_busy, stack_done, data_w8, idx_w8;
    logic [7:0]  move_src_bank, move_dst_bank, mem_rdata;
    logic [15:0] acc_a, acc_b, idx_x, idx_y, stack_ptr;
    logic [23:0] index_operand, indexed_addr, move_src_addr, move_dst_addr;
    wrs_pkg::wrs_wr_t    wr;
    wrs_pkg::wrs_op_t    stack_op;
    wrs_pkg::wrs_frame_t push_frame, pop_frame;
    wrs_pkg::wrs_mem_t   mem;
    logic [7:0]  img [0:65535];
    logic [7:0]  exp_b [0:4];
    int          fail_count = 0, compares = 0, cycles = 0, n;

    wrs_regset wrs_regset_inst (.ref_clk, .rst, .clk_en, .data_w8_set, .data_w8_clr,
        .idx_w8_set, .idx_w8_clr, .wr, .index_operand, .move_src_bank, .move_dst_bank,
        .stack_op, .call_push_bank, .push_frame, .mem_rdata, .mem_ready, .acc_a, .acc_b,
        .idx_x, .idx_y, .stack_ptr, .data_w8, .idx_w8, .indexed_addr, .move_src_addr,
        .move_dst_addr, .mem, .stack_busy, .stack_done, .pop_frame);

    // clock, 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // hang guard; the whole run needs little more than a hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic check(string what, logic [39:0] seen, logic [39:0] expd);
        compares++;
        if (seen !== expd) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, expd, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // register k of the write selector order: a, b, x, y
    function automatic logic [15:0] reg_at(int k);
        logic [63:0] all;
        all = {acc_a, acc_b, idx_x, idx_y};
        reg_at = all[63 - 16 * k -: 16];
    endfunction
    task automatic wr_reg(wrs_pkg::wrs_sel_t sel, logic [15:0] d);
        @(negedge ref_clk) wr = '{1'b1, sel, d};
        @(negedge ref_clk) wr.en = 1'b0;
    endtask
    // one-cycle pulse on a width flag control
    task automatic flag(bit idx, bit set);
        @(negedge ref_clk) {idx_w8_set, idx_w8_clr, data_w8_set, data_w8_clr} =
            idx ? {set, !set, 2'b00} : {2'b00, set, !set};
        @(negedge ref_clk) {idx_w8_set, idx_w8_clr, data_w8_set, data_w8_clr} = 4'h0;
    endtask
    // runs one stack sequence, stalling every other cycle; pushes land in img
    task automatic stack_run(wrs_pkg::wrs_op_t op, logic pb, int first, output int cnt);
        logic [15:0] s0;
        s0 = stack_ptr;
        cnt = 0;
        @(negedge ref_clk) {stack_op, call_push_bank} = {op, pb};
        @(negedge ref_clk) stack_op = wrs_pkg::WRS_OP_NONE;
        check("busy", stack_busy, 1'b1);
        for (int g = 0; g < 40 && stack_done !== 1'b1; g++) begin
            mem_ready = g[0];
            mem_rdata = mem.valid ? img[mem.addr[15:0]] : ~mem_rdata;
            if (mem.valid === 1'b1 && mem_ready && mem.write === 1'b1) begin
                img[mem.addr[15:0]] = mem.wdata;
                check("push addr", mem.addr, {8'h00, s0 - cnt[15:0]});
                check("push data", mem.wdata, exp_b[first + cnt]);
            end
            if (mem.valid === 1'b1 && mem_ready) cnt++;
            @(negedge ref_clk);
        end
        mem_ready = 1'b0;
        check("done", {stack_done, stack_busy}, 2'b10);
    endtask

    task automatic test_widths();
        check("reset flags", {data_w8, idx_w8}, 2'b00);
        for (int k = 0; k < 4; k++) begin
            wr_reg(wrs_pkg::wrs_sel_t'(k[2:0]), 16'h1234);
            flag(k > 1, 1'b1);
            wr_reg(wrs_pkg::wrs_sel_t'(k[2:0]), 16'habcd);
            check("narrow", reg_at(k), 16'h12cd);
            flag(k > 1, 1'b0);
            wr_reg(wrs_pkg::wrs_sel_t'(k[2:0]), 16'habcd);
            check("wide", reg_at(k), 16'habcd);
        end
        $display("widths done");
    endtask
    task automatic test_addr();
        wr_reg(wrs_pkg::WRS_SEL_IDX_X, 16'h0020);
        @(negedge ref_clk) {index_operand, move_src_bank, move_dst_bank} = 40'h00fff05aa5;
        #1 check("indexed", indexed_addr, 24'h010010);
        check("move src", move_src_addr, 24'h5a0020);
        check("move dst", move_dst_addr, 24'ha5abcd);
        flag(1'b1, 1'b1);
        #1 check("narrow dst", move_dst_addr, 24'ha500cd);
        flag(1'b1, 1'b0);
        // a write while the clock enable is low must leave the register alone
        @(negedge ref_clk) clk_en = 1'b0;
        wr_reg(wrs_pkg::WRS_SEL_ACC_A, 16'h5555);
        clk_en = 1'b1;
        check("frozen", acc_a, 16'habcd);
        $display("addresses done");
    endtask
    task automatic test_stack();
        exp_b = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
        push_frame = 40'h123456789a;
        wr_reg(wrs_pkg::WRS_SEL_STACK, 16'h0100);
        stack_run(wrs_pkg::WRS_OP_INTERRUPT, 1'b0, 0, n);
        check("int count", n, 5);
        check("int sp", stack_ptr, 16'h00fb);
        push_frame = 40'h0;
        stack_run(wrs_pkg::WRS_OP_RETURN, 1'b0, 0, n);
        check("pop frame", pop_frame, 40'h123456789a);
        check("ret sp", stack_ptr, 16'h0100);
        push_frame = 40'h123456789a;
        stack_run(wrs_pkg::WRS_OP_CALL, 1'b1, 0, n);
        check("call count", n, 3);
        check("call sp", stack_ptr, 16'h00fd);
        stack_run(wrs_pkg::WRS_OP_CALL, 1'b0, 1, n);
        check("short call count", n, 2);
        check("short call sp", stack_ptr, 16'h00fb);
        $display("stack done");
    endtask

    // reset for 10 cycles, then the scenarios in turn
    initial begin
        {rst, clk_en, call_push_bank, mem_ready, mem_rdata} = {3'b110, 9'h0};
        {data_w8_set, data_w8_clr, idx_w8_set, idx_w8_clr} = 4'h0;
        {wr, stack_op, push_frame, index_operand} = '0;
        {move_src_bank, move_dst_bank} = 16'h0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        test_widths();
        test_addr();
        test_stack();
        tally_and_finish();
    end
endmodule // testbench

bind wrs_regset wrs_regset_checker wrs_regset_checker_inst (.ref_clk, .rst, .clk_en,
    .mem_ready, .stack_busy, .wr, .stack_op, .push_frame, .index_operand, .move_src_bank,
    .move_dst_bank, .acc_a, .idx_x, .idx_y, .stack_ptr, .data_w8, .idx_w8, .indexed_addr,
    .move_src_addr, .move_dst_addr, .mem);
